// *** dcocfg_pkg.sv ***
// Constants for the calibration and mixer setup word storage.
// Assumes a three-wire serial host shifting 32-bit words, bit 0 first.
package dcocfg_pkg;

  localparam int unsigned WORD_W        = 32;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned CNT_W         = 6;
  localparam int unsigned SYNC_STAGES   = 3;

  // Word addresses in bits 0 to 4
  localparam logic [4:0]  ADDR_CAL_WORD = 5'h0A;
  localparam logic [4:0]  ADDR_MIX_WORD = 5'h0B;
  localparam logic [5:0]  FRAME_BITS    = 6'h20;

  // Reset values of the two setup words
  localparam logic [31:0] CAL_WORD_RST  = 32'h71E0_200A;
  localparam logic [31:0] MIX_WORD_RST  = 32'h4000_000B;

  // Calibration setup word fields
  localparam int unsigned AUTOCAL_BIT   = 5;
  localparam int unsigned IDAC_LSB      = 6;
  localparam int unsigned IDAC_MSB      = 13;
  localparam int unsigned QDAC_LSB      = 14;
  localparam int unsigned QDAC_MSB      = 21;
  localparam int unsigned IREF_LSB      = 22;
  localparam int unsigned IREF_MSB      = 23;
  localparam int unsigned CALSEL_BIT    = 24;
  localparam int unsigned DIV_LSB       = 25;
  localparam int unsigned DIV_MSB       = 27;
  localparam int unsigned CLKSRC_BIT    = 28;
  localparam int unsigned TRIM_LSB      = 29;
  localparam int unsigned TRIM_MSB      = 31;

  // Mixer load and filter setup word fields
  localparam int unsigned ILA_LSB       = 5;
  localparam int unsigned ILA_MSB       = 10;
  localparam int unsigned ILB_LSB       = 11;
  localparam int unsigned ILB_MSB       = 16;
  localparam int unsigned QLA_LSB       = 17;
  localparam int unsigned QLA_MSB       = 22;
  localparam int unsigned QLB_LSB       = 23;
  localparam int unsigned QLB_MSB       = 28;
  localparam int unsigned BYPASS_BIT    = 29;
  localparam int unsigned PEAK_LSB      = 30;
  localparam int unsigned PEAK_MSB      = 31;

endpackage

// *** dcocfg_regs.sv ***
// Serial loaded setup words for dc offset calibration and mixer trim.
// Assumes serial pins are asynchronous and a calibration engine on sys_clk.
// Notes on behaviour
// - Calibration word bits 6-13 hold in-phase DAC code, reset 0x80, used in manual.
// - Calibration word bits 14-21 hold quadrature DAC code, reset 0x80, used in manual.
// - Bits 22-23 pick detector reference current, reset 11, 00 finest.
// - Bit 24 picks calibration method, 0 manual, 1 automatic, reset 1.
// - Bits 25-27 pick calibration clock divide ratio, reset 000.
// - Bit 28 picks calibration clock, 1 oscillator, 0 serial clock, reset 1.
// - Bits 29-31 trim oscillator frequency, reset 011.
// - Mixer word bits 5-10 and 11-16 hold in-phase load A and B, reset zero.
// - Mixer word bits 17-22 and 23-28 hold quadrature load A and B, reset zero.
// - Calibration word bit 5 starts automatic calibration, cleared when it completes.
`timescale 1ns/1ps
module dcocfg_regs
  import dcocfg_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 nrst_in,
  input  wire logic                 clk_en_in,
  // Three-wire serial pins
  input  wire logic                 ser_clk_in,
  input  wire logic                 ser_data_in,
  input  wire logic                 ser_latch_in,
  // Calibration engine
  input  wire logic                 cal_done_in,
  output logic                      cal_start_out,
  output logic                      autocal_en_out,
  // Calibration setup fields
  output logic [7:0]                inphase_offset_dac_code_out,
  output logic [7:0]                quad_offset_dac_code_out,
  output logic [1:0]                cal_reference_current_sel_out,
  output logic                      cal_auto_mode_out,
  output logic [2:0]                cal_clk_div_sel_out,
  output logic                      cal_clk_osc_sel_out,
  output logic [2:0]                osc_trim_out,
  // Mixer load and filter fields
  output logic [5:0]                inphase_mixer_load_side_a_out,
  output logic [5:0]                inphase_mixer_load_side_b_out,
  output logic [5:0]                quad_mixer_load_side_a_out,
  output logic [5:0]                quad_mixer_load_side_b_out,
  output logic                      filter_bypass_out,
  output logic [1:0]                filter_peaking_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SYNC_STAGES-1:0] sclk_sync_ff;
  logic [SYNC_STAGES-1:0] sdat_sync_ff;
  logic [SYNC_STAGES-1:0] slat_sync_ff;
  logic                   sclk_lvl_ff;
  logic                   slat_lvl_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sclk_sync_ff <= '0;
      sdat_sync_ff <= '0;
      slat_sync_ff <= '0;
    end
    else if (clk_en_in)
    begin
      sclk_sync_ff <= {sclk_sync_ff[SYNC_STAGES-2:0], ser_clk_in};
      sdat_sync_ff <= {sdat_sync_ff[SYNC_STAGES-2:0], ser_data_in};
      slat_sync_ff <= {slat_sync_ff[SYNC_STAGES-2:0], ser_latch_in};
    end
  end

  // Level counts once second and third stages agree
  logic sclk_agree;
  logic slat_agree;
  assign sclk_agree = (sclk_sync_ff[1] == sclk_sync_ff[2]);
  assign slat_agree = (slat_sync_ff[1] == slat_sync_ff[2]);

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sclk_lvl_ff <= 1'b0;
      slat_lvl_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (sclk_agree)
        sclk_lvl_ff <= sclk_sync_ff[2];
      if (slat_agree)
        slat_lvl_ff <= slat_sync_ff[2];
    end
  end

  logic sclk_rise;
  logic slat_rise;
  assign sclk_rise = sclk_agree && sclk_sync_ff[2] && !sclk_lvl_ff;
  assign slat_rise = slat_agree && slat_sync_ff[2] && !slat_lvl_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter, bit 0 first
  logic [WORD_W-1:0] shift_ff;
  logic [CNT_W-1:0]  bitcnt_ff;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      shift_ff  <= '0;
      bitcnt_ff <= '0;
    end
    else if (clk_en_in)
    begin
      if (slat_rise)
        bitcnt_ff <= '0;
      else if (sclk_rise && !slat_lvl_ff)
      begin
        shift_ff <= {sdat_sync_ff[2], shift_ff[WORD_W-1:1]};
        if (bitcnt_ff != {CNT_W{1'b1}})
          bitcnt_ff <= bitcnt_ff + 1'b1;
      end
    end
  end

  logic frame_ok;
  logic load_cal;
  logic load_mix;
  assign frame_ok = slat_rise && (bitcnt_ff == FRAME_BITS);
  assign load_cal = frame_ok && (shift_ff[ADDR_W-1:0] == ADDR_CAL_WORD);
  assign load_mix = frame_ok && (shift_ff[ADDR_W-1:0] == ADDR_MIX_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // Setup words
  logic [WORD_W-1:0] cal_word_ff;
  logic [WORD_W-1:0] mix_word_ff;
  logic              nxt_autocal;

  // Set from a frame wins over completion
  always_comb
  begin
    nxt_autocal = cal_word_ff[AUTOCAL_BIT];
    if (cal_done_in)
      nxt_autocal = 1'b0;
    if (load_cal)
      nxt_autocal = shift_ff[AUTOCAL_BIT];
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cal_word_ff <= CAL_WORD_RST;
    else if (clk_en_in)
    begin
      if (load_cal)
        cal_word_ff <= shift_ff;
      cal_word_ff[AUTOCAL_BIT] <= nxt_autocal;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      mix_word_ff <= MIX_WORD_RST;
    else if (clk_en_in && load_mix)
      mix_word_ff <= shift_ff;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cal_start_out <= 1'b0;
    else if (clk_en_in)
      cal_start_out <= load_cal && shift_ff[AUTOCAL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field outputs
  assign autocal_en_out                = cal_word_ff[AUTOCAL_BIT];
  assign inphase_offset_dac_code_out   = cal_word_ff[IDAC_MSB:IDAC_LSB];
  assign quad_offset_dac_code_out      = cal_word_ff[QDAC_MSB:QDAC_LSB];
  assign cal_reference_current_sel_out = cal_word_ff[IREF_MSB:IREF_LSB];
  assign cal_auto_mode_out             = cal_word_ff[CALSEL_BIT];
  assign cal_clk_div_sel_out           = cal_word_ff[DIV_MSB:DIV_LSB];
  assign cal_clk_osc_sel_out           = cal_word_ff[CLKSRC_BIT];
  assign osc_trim_out                  = cal_word_ff[TRIM_MSB:TRIM_LSB];
  assign inphase_mixer_load_side_a_out = mix_word_ff[ILA_MSB:ILA_LSB];
  assign inphase_mixer_load_side_b_out = mix_word_ff[ILB_MSB:ILB_LSB];
  assign quad_mixer_load_side_a_out    = mix_word_ff[QLA_MSB:QLA_LSB];
  assign quad_mixer_load_side_b_out    = mix_word_ff[QLB_MSB:QLB_LSB];
  assign filter_bypass_out             = mix_word_ff[BYPASS_BIT];
  assign filter_peaking_out            = mix_word_ff[PEAK_MSB:PEAK_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_cal_word_load: assert property (
    clk_en_in && load_cal |=> cal_word_ff[WORD_W-1:IDAC_LSB] == $past(shift_ff[WORD_W-1:IDAC_LSB]))
    else $error("Calibration word not loaded from frame");

  a_mix_word_load: assert property (
    clk_en_in && load_mix |=> mix_word_ff == $past(shift_ff))
    else $error("Mixer word not loaded from frame");

  a_partial_ignored: assert property (
    clk_en_in && slat_rise && bitcnt_ff != FRAME_BITS
    |=> $stable(mix_word_ff) && $stable(cal_word_ff[WORD_W-1:IDAC_LSB]))
    else $error("Partial frame changed a setup word");

  a_addr_select: assert property (
    clk_en_in && frame_ok && shift_ff[ADDR_W-1:0] != ADDR_MIX_WORD |=> $stable(mix_word_ff))
    else $error("Mixer word loaded with foreign address");

  a_autocal_clear: assert property (
    clk_en_in && cal_done_in && !load_cal |=> !autocal_en_out)
    else $error("Autocal enable not cleared on completion");

  a_autocal_set_wins: assert property (
    clk_en_in && cal_done_in && load_cal && shift_ff[AUTOCAL_BIT]
    |=> autocal_en_out ##0 cal_start_out)
    else $error("Autocal request lost against completion");

  a_start_cause: assert property (
    cal_start_out && $past(clk_en_in) |-> $past(load_cal) && autocal_en_out)
    else $error("Calibration start without a request");

  a_enable_freeze: assert property (
    !clk_en_in |=> $stable(cal_word_ff) && $stable(mix_word_ff) && $stable(bitcnt_ff))
    else $error("State moved while clock enable low");

  c_cal_load:    cover property (clk_en_in && load_cal);
  c_mix_load:    cover property (clk_en_in && load_mix);
  c_autocal_run: cover property (cal_start_out ##[1:200] !autocal_en_out);
  c_partial:     cover property (clk_en_in && slat_rise && bitcnt_ff != FRAME_BITS);

endmodule

// *** dcocfg_host.sv ***
// Host model shifting serial frames into the setup words.
// Assumes the bench clock; pins change just after its rising edge.
`timescale 1ns/1ps
module dcocfg_host
(
  // Clock
  input  wire logic sys_clk_in,
  // Serial pins
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_latch_out
);
  initial
  begin
    ser_clk_out   = 1'b0;
    ser_data_out  = 1'b0;
    ser_latch_out = 1'b1;
  end

  task automatic hold();
    repeat (4) @(posedge sys_clk_in);
  endtask

  // Bits 0 to 4 carry the word address, bit 0 first
  task automatic send(input logic [39:0] word, input int nbits);
    ser_latch_out <= 1'b0;
    hold();
    for (int i = 0; i < nbits; i++)
    begin
      ser_data_out <= word[i];
      hold();
      ser_clk_out <= 1'b1;
      hold();
      ser_clk_out <= 1'b0;
      hold();
    end
    // Released data line shows the inverse of the last bit
    ser_data_out  <= ~ser_data_out;
    ser_latch_out <= 1'b1;
    hold();
  endtask
endmodule

// *** dcocfg_regs_bench.sv ***
// Bench for the serial loaded setup words.
// Assumes the host model drives the three serial pins.
`timescale 1ns/1ps
module dcocfg_regs_bench;
  import dcocfg_pkg::*;

  logic        sys_clk, nrst, clk_en, cal_done, ser_clk, ser_data, ser_latch;
  logic        cal_start, autocal;
  logic [7:0]  idac, qdac;
  logic [1:0]  iref, peak;
  logic [2:0]  div, trim;
  logic        amode, osc, byp;
  logic [5:0]  ila, ilb, qla, qlb;
  logic [31:0] cal_w, mix_w, w;
  logic [2:0]  c;
  logic [7:0]  dac;
  int          num_errors, n_tests, starts, cycles;

  dcocfg_regs u_dcocfg_regs (.sys_clk_in(sys_clk), .nrst_in(nrst), .clk_en_in(clk_en),
    .ser_clk_in(ser_clk), .ser_data_in(ser_data), .ser_latch_in(ser_latch),
    .cal_done_in(cal_done), .cal_start_out(cal_start), .autocal_en_out(autocal),
    .inphase_offset_dac_code_out(idac), .quad_offset_dac_code_out(qdac),
    .cal_reference_current_sel_out(iref), .cal_auto_mode_out(amode),
    .cal_clk_div_sel_out(div), .cal_clk_osc_sel_out(osc), .osc_trim_out(trim),
    .inphase_mixer_load_side_a_out(ila), .inphase_mixer_load_side_b_out(ilb),
    .quad_mixer_load_side_a_out(qla), .quad_mixer_load_side_b_out(qlb),
    .filter_bypass_out(byp), .filter_peaking_out(peak));

  dcocfg_host u_dcocfg_host (.sys_clk_in(sys_clk), .ser_clk_out(ser_clk),
    .ser_data_out(ser_data), .ser_latch_out(ser_latch));

  assign cal_w = {trim, osc, div, amode, iref, qdac, idac, autocal, 5'h0A};
  assign mix_w = {peak, byp, qlb, qla, ilb, ila, 5'h0B};

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Frame then compare both words
  task automatic xfer(input logic [39:0] word, input int nbits,
                      input logic [31:0] ecal, input logic [31:0] emix);
    u_dcocfg_host.send(word, nbits);
    repeat (3) @(posedge sys_clk);
    check(cal_w, ecal);
    check(mix_w, emix);
  endtask

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cal_start === 1'b1)
      starts++;
    if (cycles == 12000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    nrst     <= 1'b0;
    clk_en   <= 1'b1;
    cal_done <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(cal_w, 32'h71E0_200A);
    check(mix_w, 32'h4000_000B);
    for (int k = 0; k < 8; k++)
    begin
      c = k[2:0];
      dac = {c, ~c, c[1:0]};
      w = {c, c[0], c, ~c[0], c[1:0], ~dac, dac, 1'b0, 5'h0A};
      xfer({8'h00, w}, 32, w, 32'h4000_000B);
    end
    xfer(40'h00_227E_AAAB, 32, w, 32'h227E_AAAB);
    xfer(40'h00_5F01_554B, 32, w, 32'h5F01_554B);
    xfer(40'h00_FFFF_FFEC, 32, w, 32'h5F01_554B);
    xfer(40'h00_CE30_CF1A, 32, w, 32'h5F01_554B);
    xfer(40'h00_CE30_CF0A, 31, w, 32'h5F01_554B);
    xfer(40'h01_CE30_CF0A, 33, w, 32'h5F01_554B);
    check(32'(starts), 32'h0000_0000);
    xfer(40'h00_CE30_CF2A, 32, 32'hCE30_CF2A, 32'h5F01_554B);
    check(32'(starts), 32'h0000_0001);
    cal_done <= 1'b1;
    @(posedge sys_clk);
    cal_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(cal_w, 32'hCE30_CF0A);
    // Completion held high across a start request: the request wins once
    cal_done <= 1'b1;
    xfer(40'h00_3A5C_C3AA, 32, 32'h3A5C_C38A, 32'h5F01_554B);
    check(32'(starts), 32'h0000_0002);
    // Frame sent while the clock enable is low must not load
    cal_done <= 1'b0;
    clk_en   <= 1'b0;
    xfer(40'h00_0000_000B, 32, 32'h3A5C_C38A, 32'h5F01_554B);
    // Reset in mid-run brings both words back
    clk_en <= 1'b1;
    nrst   <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(cal_w, 32'h71E0_200A);
    check(mix_w, 32'h4000_000B);
    report_and_stop();
  end
endmodule
